// ---- inc/bfw_pkg.sv ----
// constants for the bridge forwarding window register bank
// Functional notes
// - memory window steers memory forwarding decision
// - memory bottom bits 15:4 give address 31:20
// - memory top bits 31:20, low bits ones
// - prefetch low nibbles read fixed 0001
// - prefetch window steers memory read/write forwarding
// - prefetch bottom 31:20, upper half separate
// - prefetch top 31:20, low bits ones
// - prefetch bottom upper dword, writable, reset zero
// - prefetch top upper dword, writable, reset zero
// - io bottom upper sixteen bits, reset zero
// - io top upper sixteen bits, reset zero
// - capability pointer reads fixed 80h
// - io bottom 15:12 from nibble, rest zero
// - io top 15:12 from nibble, rest ones
package bfw_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int BE_W = 4;
    localparam int NUM_WORDS = 7;
    localparam logic [3:0] IDX_NONE = 4'hf;
    // word index order: io low, memory, prefetch low, prefetch upper pair, io upper, cap
    localparam int IDX_IO_LOW = 0;
    localparam int IDX_MEM = 1;
    localparam int IDX_PREF = 2;
    localparam int IDX_PREF_BOT_HI = 3;
    localparam int IDX_PREF_TOP_HI = 4;
    localparam int IDX_IO_HI = 5;
    localparam int IDX_CAP = 6;
    localparam logic [7:0] OFS [NUM_WORDS] = '{8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h34};
    localparam logic [31:0] WMASK [NUM_WORDS] = '{32'h0000f0f0, 32'hfff0fff0, 32'hfff0fff0,
        32'hffffffff, 32'hffffffff, 32'hffffffff, 32'h00000000};
    localparam logic [31:0] ROFIX [NUM_WORDS] = '{32'h00000101, 32'h00000000, 32'h00010001,
        32'h00000000, 32'h00000000, 32'h00000000, 32'h00000080};
    localparam logic [31:0] WORD_RESET = 32'h00000000;
    // field positions inside the words
    localparam int BOT12_LSB = 4;
    localparam int TOP12_LSB = 20;
    localparam int NIB_BOT_LSB = 4;
    localparam int NIB_TOP_LSB = 12;
    localparam int HI16_BOT_LSB = 0;
    localparam int HI16_TOP_LSB = 16;
    // implied low address bits of each window edge
    localparam logic [19:0] FILL20_ZERO = 20'h00000;
    localparam logic [19:0] FILL20_ONES = 20'hfffff;
    localparam logic [11:0] FILL12_ZERO = 12'h000;
    localparam logic [11:0] FILL12_ONES = 12'hfff;
    localparam logic [31:0] UPPER_ZERO = 32'h00000000;
endpackage

// ---- verilog/bfw_range_cmp.sv ----
// inclusive address window comparator
`timescale 1ns/1ps
`default_nettype none
module bfw_range_cmp #(
    parameter int W = 32
) (
    input wire logic [W-1:0] i_addr,
    input wire logic [W-1:0] i_bottom,
    input wire logic [W-1:0] i_top,
    output logic o_hit
);
    // both edges inclusive; bottom above top gives an empty window
    assign o_hit = (i_addr >= i_bottom) && (i_addr <= i_top);
endmodule
`default_nettype wire

// ---- verilog/bfw_wait_gen.sv ----
// avalon waitrequest generator, one wait state per access
`timescale 1ns/1ps
`default_nettype none
module bfw_wait_gen (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_request,
    output logic o_waitrequest,
    output logic o_accept
);
    logic wait_q;
    // high by default so a request is never taken before decode settles
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            wait_q <= 1'b1;
        end else if (i_request && wait_q) begin
            wait_q <= 1'b0;
        end else begin
            wait_q <= 1'b1;
        end
    end
    assign o_waitrequest = wait_q;
    // the master samples waitrequest low at this edge
    assign o_accept = i_request && !wait_q;
endmodule
`default_nettype wire

// ---- verilog/bfw_window_regs.sv ----
// forwarding window registers with avalon slave and window lookup
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module bfw_window_regs (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_lookup_valid,
    input wire logic [63:0] i_lookup_addr,
    input wire logic i_lookup_is_io,
    output logic o_lookup_done,
    output logic o_mem_hit,
    output logic o_pref_hit,
    output logic o_io_hit
);
    logic [31:0] word_q [bfw_pkg::NUM_WORDS];
    logic [31:0] readdata_q;
    logic [31:0] rd_value;
    logic [3:0] rd_idx;
    logic [3:0] wr_idx;
    logic request;
    logic accept;
    logic first_cycle;
    logic wr_commit;
    logic lookup_done_q;
    logic mem_hit_q;
    logic pref_hit_q;
    logic io_hit_q;
    logic [31:0] mem_bottom;
    logic [31:0] mem_top;
    logic [63:0] pref_bottom;
    logic [63:0] pref_top;
    logic [31:0] io_bottom;
    logic [31:0] io_top;
    logic mem_in;
    logic pref_in;
    logic io_in;
    logic addr_below_4g;

    // address decode, shared by the read capture and the write commit
    function automatic logic [3:0] reg_index(input logic [7:0] addr);
        logic [3:0] idx;
        idx = bfw_pkg::IDX_NONE;
        for (int i = 0; i < bfw_pkg::NUM_WORDS; i++) begin
            if (addr == bfw_pkg::OFS[i]) begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction

    // byte lane merge, then drop every read-only and reserved bit
    function automatic logic [31:0] merge_word(
        input logic [31:0] old,
        input logic [31:0] wdata,
        input logic [3:0] be,
        input logic [31:0] mask
    );
        logic [31:0] res;
        res = old;
        for (int b = 0; b < bfw_pkg::BE_W; b++) begin
            if (be[b]) begin
                res[8*b +: 8] = wdata[8*b +: 8];
            end
        end
        return res & mask;
    endfunction

    // bus handshake: a request waits one cycle, then is accepted
    assign request = i_avs_read || i_avs_write;

    bfw_wait_gen u_wait (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_request(request),
        .o_waitrequest(o_avs_waitrequest),
        .o_accept(accept)
    );

    assign first_cycle = request && o_avs_waitrequest;
    assign wr_commit = accept && i_avs_write;
    assign rd_idx = reg_index(i_avs_address);
    assign wr_idx = reg_index(i_avs_address);

    // one storage word per offset; generated since every word behaves alike
    for (genvar g = 0; g < bfw_pkg::NUM_WORDS; g++) begin : g_word
        always_ff @(posedge i_clock or posedge i_rst) begin
            if (i_rst) begin
                word_q[g] <= bfw_pkg::WORD_RESET;
            end else if (wr_commit && wr_idx == 4'(g)) begin
                word_q[g] <= merge_word(word_q[g], i_avs_writedata, i_avs_byteenable,
                    bfw_pkg::WMASK[g]);
            end
        end
    end

    // read view: stored bits plus the fixed read-only patterns
    always_comb begin
        rd_value = 32'h00000000;
        for (int i = 0; i < bfw_pkg::NUM_WORDS; i++) begin
            if (rd_idx == 4'(i)) begin
                rd_value = word_q[i] | bfw_pkg::ROFIX[i];
            end
        end
    end

    // read data latched in the wait cycle, stands through the accept edge
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            readdata_q <= 32'h00000000;
        end else if (first_cycle && i_avs_read) begin
            readdata_q <= rd_value;
        end
    end
    assign o_avs_readdata = readdata_q;

    // window edges built from the stored fields and implied low bits
    assign mem_bottom = {word_q[bfw_pkg::IDX_MEM][bfw_pkg::BOT12_LSB +: 12],
        bfw_pkg::FILL20_ZERO};
    assign mem_top = {word_q[bfw_pkg::IDX_MEM][bfw_pkg::TOP12_LSB +: 12],
        bfw_pkg::FILL20_ONES};
    assign pref_bottom = {word_q[bfw_pkg::IDX_PREF_BOT_HI],
        word_q[bfw_pkg::IDX_PREF][bfw_pkg::BOT12_LSB +: 12], bfw_pkg::FILL20_ZERO};
    assign pref_top = {word_q[bfw_pkg::IDX_PREF_TOP_HI],
        word_q[bfw_pkg::IDX_PREF][bfw_pkg::TOP12_LSB +: 12], bfw_pkg::FILL20_ONES};
    assign io_bottom = {word_q[bfw_pkg::IDX_IO_HI][bfw_pkg::HI16_BOT_LSB +: 16],
        word_q[bfw_pkg::IDX_IO_LOW][bfw_pkg::NIB_BOT_LSB +: 4],
        bfw_pkg::FILL12_ZERO};
    assign io_top = {word_q[bfw_pkg::IDX_IO_HI][bfw_pkg::HI16_TOP_LSB +: 16],
        word_q[bfw_pkg::IDX_IO_LOW][bfw_pkg::NIB_TOP_LSB +: 4],
        bfw_pkg::FILL12_ONES};

    bfw_range_cmp #(.W(32)) u_mem_cmp (
        .i_addr(i_lookup_addr[31:0]),
        .i_bottom(mem_bottom),
        .i_top(mem_top),
        .o_hit(mem_in)
    );

    bfw_range_cmp #(.W(64)) u_pref_cmp (
        .i_addr(i_lookup_addr),
        .i_bottom(pref_bottom),
        .i_top(pref_top),
        .o_hit(pref_in)
    );

    bfw_range_cmp #(.W(32)) u_io_cmp (
        .i_addr(i_lookup_addr[31:0]),
        .i_bottom(io_bottom),
        .i_top(io_top),
        .o_hit(io_in)
    );

    // the 32-bit memory and io windows live below 4 GB only
    assign addr_below_4g = i_lookup_addr[63:32] == bfw_pkg::UPPER_ZERO;

    // done strobe: one pulse per lookup cycle, back to back allowed
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            lookup_done_q <= 1'b0;
        end else begin
            lookup_done_q <= i_lookup_valid;
        end
    end

    // memory window decision, registered one cycle after the request
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            mem_hit_q <= 1'b0;
        end else begin
            mem_hit_q <= i_lookup_valid && !i_lookup_is_io && mem_in && addr_below_4g;
        end
    end

    // prefetch window decision over the full 64-bit address
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            pref_hit_q <= 1'b0;
        end else begin
            pref_hit_q <= i_lookup_valid && !i_lookup_is_io && pref_in;
        end
    end

    // io window decision; io space has no upper dword
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            io_hit_q <= 1'b0;
        end else begin
            io_hit_q <= i_lookup_valid && i_lookup_is_io && io_in && addr_below_4g;
        end
    end

    // flags fall back low between lookups, so readers must qualify with done
    assign o_lookup_done = lookup_done_q;
    assign o_mem_hit = mem_hit_q;
    assign o_pref_hit = pref_hit_q;
    assign o_io_hit = io_hit_q;

    // checks on the register bank and the window decisions
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_rst);

    a_mem_low_zero:
    assert property (accept && i_avs_read && i_avs_address == bfw_pkg::OFS[bfw_pkg::IDX_MEM]
        |-> o_avs_readdata[3:0] == 4'h0 && o_avs_readdata[19:16] == 4'h0)
        else $error("memory word reserved bits not zero");

    a_pref_indicator:
    assert property (accept && i_avs_read && i_avs_address == bfw_pkg::OFS[bfw_pkg::IDX_PREF]
        |-> o_avs_readdata[3:0] == 4'h1 && o_avs_readdata[19:16] == 4'h1)
        else $error("prefetch indicator nibbles wrong");

    a_cap_pointer:
    assert property (accept && i_avs_read && i_avs_address == bfw_pkg::OFS[bfw_pkg::IDX_CAP]
        |-> o_avs_readdata == 32'h00000080)
        else $error("capability pointer wrong");

    a_ro_write_drop:
    assert property (wr_commit && i_avs_address == bfw_pkg::OFS[bfw_pkg::IDX_MEM]
        |=> word_q[bfw_pkg::IDX_MEM][3:0] == 4'h0 && word_q[bfw_pkg::IDX_MEM][19:16] == 4'h0)
        else $error("read-only memory bits were written");

    a_pref_bot_upper:
    assert property (wr_commit && i_avs_byteenable == 4'hf
        && i_avs_address == bfw_pkg::OFS[bfw_pkg::IDX_PREF_BOT_HI]
        |=> word_q[bfw_pkg::IDX_PREF_BOT_HI] == $past(i_avs_writedata))
        else $error("prefetch bottom upper dword not stored");

    a_io_upper_store:
    assert property (wr_commit && i_avs_byteenable == 4'hf
        && i_avs_address == bfw_pkg::OFS[bfw_pkg::IDX_IO_HI]
        |=> io_bottom[31:16] == $past(i_avs_writedata[15:0])
        && io_top[31:16] == $past(i_avs_writedata[31:16]))
        else $error("io upper halves not stored");

    a_mem_window_hit:
    assert property (i_lookup_valid && !i_lookup_is_io && i_lookup_addr[63:32] == 32'h0
        && i_lookup_addr[31:20] >= word_q[bfw_pkg::IDX_MEM][15:4]
        && i_lookup_addr[31:20] <= word_q[bfw_pkg::IDX_MEM][31:20]
        |=> o_mem_hit && o_lookup_done)
        else $error("memory window missed");

    a_pref_top_edge:
    assert property (i_lookup_valid && !i_lookup_is_io && i_lookup_addr == pref_top
        && pref_bottom <= pref_top |=> o_pref_hit)
        else $error("prefetch top edge not inclusive");

    a_io_past_top:
    assert property (i_lookup_valid && i_lookup_is_io && io_top != 32'hffffffff
        && i_lookup_addr == {32'h0, io_top + 32'h1} |=> !o_io_hit)
        else $error("io window ran past its top");

    a_wait_answer:
    assert property ($rose(request) && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("request not answered after one wait");

    // window edges, hit ranges and field stores, checked against both the edge nets and the stored fields
    a_mem_top_edge:
    assert property (i_lookup_valid && !i_lookup_is_io && i_lookup_addr == {32'h0, mem_top}
        && mem_bottom <= mem_top |=> o_mem_hit)
        else $error("memory top edge not inclusive");

    a_mem_below_bottom:
    assert property (i_lookup_valid && !i_lookup_is_io && mem_bottom != 32'h0
        && i_lookup_addr == {32'h0, mem_bottom - 32'h1} |=> !o_mem_hit)
        else $error("memory window reached below its bottom");

    a_upper_dword_miss:
    assert property (i_lookup_valid && i_lookup_addr[63:32] != 32'h0
        |=> !o_mem_hit && !o_io_hit)
        else $error("32-bit window hit above 4 GB");

    a_pref_window_hit:
    assert property (i_lookup_valid && !i_lookup_is_io
        && i_lookup_addr[63:20] >= {word_q[bfw_pkg::IDX_PREF_BOT_HI],
        word_q[bfw_pkg::IDX_PREF][15:4]}
        && i_lookup_addr[63:20] <= {word_q[bfw_pkg::IDX_PREF_TOP_HI],
        word_q[bfw_pkg::IDX_PREF][31:20]}
        |=> o_pref_hit && o_lookup_done)
        else $error("prefetch window missed");

    a_pref_bottom_edge:
    assert property (i_lookup_valid && !i_lookup_is_io && i_lookup_addr == pref_bottom
        && pref_bottom <= pref_top |=> o_pref_hit)
        else $error("prefetch bottom edge not inclusive");

    a_pref_top_upper:
    assert property (wr_commit && i_avs_byteenable == 4'hf
        && i_avs_address == bfw_pkg::OFS[bfw_pkg::IDX_PREF_TOP_HI]
        |=> word_q[bfw_pkg::IDX_PREF_TOP_HI] == $past(i_avs_writedata))
        else $error("prefetch top upper dword not stored");

    a_mem_fields_store:
    assert property (wr_commit && i_avs_byteenable == 4'hf
        && i_avs_address == bfw_pkg::OFS[bfw_pkg::IDX_MEM]
        |=> word_q[bfw_pkg::IDX_MEM][15:4] == $past(i_avs_writedata[15:4])
        && word_q[bfw_pkg::IDX_MEM][31:20] == $past(i_avs_writedata[31:20]))
        else $error("memory window fields not stored");

    a_io_nibble_store:
    assert property (wr_commit && i_avs_byteenable == 4'hf
        && i_avs_address == bfw_pkg::OFS[bfw_pkg::IDX_IO_LOW]
        |=> io_bottom[15:12] == $past(i_avs_writedata[7:4])
        && io_top[15:12] == $past(i_avs_writedata[15:12]))
        else $error("io low nibbles not stored");

    a_io_window_hit:
    assert property (i_lookup_valid && i_lookup_is_io && i_lookup_addr[63:32] == 32'h0
        && i_lookup_addr[31:12] >= {word_q[bfw_pkg::IDX_IO_HI][15:0],
        word_q[bfw_pkg::IDX_IO_LOW][7:4]}
        && i_lookup_addr[31:12] <= {word_q[bfw_pkg::IDX_IO_HI][31:16],
        word_q[bfw_pkg::IDX_IO_LOW][15:12]}
        |=> o_io_hit && o_lookup_done)
        else $error("io window missed");

    a_io_top_edge:
    assert property (i_lookup_valid && i_lookup_is_io && i_lookup_addr == {32'h0, io_top}
        && io_bottom <= io_top |=> o_io_hit)
        else $error("io top edge not inclusive");

    // transaction kind keeps io and memory decisions apart; then done, idle, unmapped read and wait checks
    a_io_no_mem:
    assert property (i_lookup_valid && i_lookup_is_io |=> !o_mem_hit && !o_pref_hit)
        else $error("io lookup hit a memory window");

    a_mem_no_io:
    assert property (i_lookup_valid && !i_lookup_is_io |=> !o_io_hit)
        else $error("memory lookup hit the io window");

    a_done_pulse:
    assert property (i_lookup_valid |=> o_lookup_done)
        else $error("lookup not answered in one cycle");

    a_idle_quiet:
    assert property (!i_lookup_valid
        |=> !o_lookup_done && !o_mem_hit && !o_pref_hit && !o_io_hit)
        else $error("lookup outputs active without a request");

    a_unmapped_zero:
    assert property (accept && i_avs_read && rd_idx == bfw_pkg::IDX_NONE
        |-> o_avs_readdata == 32'h00000000)
        else $error("unmapped read not zero");

    a_wait_single:
    assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("waitrequest low for more than one cycle");

    c_reg_write: cover property (wr_commit);
    c_read_accept: cover property (accept && i_avs_read);
    c_mem_hit: cover property (o_mem_hit);
    c_pref_hit: cover property (o_pref_hit);
    c_io_hit: cover property (o_io_hit);
endmodule
`default_nettype wire

// ---- testbench/bfw_host_model.sv ----
// host-side avalon master model that configures the window registers
`timescale 1ns/1ps
`default_nettype none
module bfw_host_model (
    input wire logic i_clock,
    input wire logic i_waitrequest,
    output logic [7:0] o_address,
    output logic o_read,
    output logic o_write,
    output logic [31:0] o_writedata,
    output logic [3:0] o_byteenable
);
    // bus idle at time zero
    initial begin
        o_address = 8'h00;
        o_read = 1'b0;
        o_write = 1'b0;
        o_writedata = 32'h00000000;
        o_byteenable = 4'h0;
    end
    // one access, held until waitrequest is seen low at an edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] be, input int gap);
        repeat (gap + 1) @(posedge i_clock);
        o_read <= ~w;
        o_write <= w;
        o_address <= a;
        o_writedata <= d;
        o_byteenable <= be;
        do @(posedge i_clock); while (i_waitrequest !== 1'b0);
        // released address and data lines flip, so stale values never pass for data
        o_read <= 1'b0;
        o_write <= 1'b0;
        o_address <= ~a;
        o_writedata <= ~d;
    endtask
endmodule
`default_nettype wire

// ---- testbench/test_bridge_forwarding_window_regs.sv ----
// self-checking bench for the forwarding window register bank
`timescale 1ns/1ps
`default_nettype none
module test_bridge_forwarding_window_regs;
    logic clock, rst, rd, wr, waitreq, lk_valid, lk_io, lk_done, mem_hit, pref_hit, io_hit;
    logic [7:0] address;
    logic [31:0] wdata, rdata;
    logic [3:0] be;
    logic [63:0] lk_addr;
    int fail_count = 0;
    int num_checks = 0;
    logic [31:0] seed = 32'h0000004a;
    logic [31:0] m [7];
    logic [31:0] exp_rd [$];
    logic [2:0] exp_lk [$];
    localparam logic [31:0] WR_MASK [7] = '{32'h0000f0f0, 32'hfff0fff0, 32'hfff0fff0,
        32'hffffffff, 32'hffffffff, 32'hffffffff, 32'h00000000};
    localparam logic [31:0] RO_BITS [7] = '{32'h00000101, 32'h00000000, 32'h00010001,
        32'h00000000, 32'h00000000, 32'h00000000, 32'h00000080};
    localparam logic [31:0] WIN_CFG [6] = '{32'h00007030, 32'h45601230, 32'h9ab03450,
        32'h00000001, 32'h00000002, 32'h00050002};
    localparam logic [63:0] EDGES [6] = '{64'h12300000, 64'h456fffff, 64'h134500000,
        64'h29abfffff, 64'h00023000, 64'h00057fff};

    bfw_window_regs i_bfw_window_regs (.i_clock(clock), .i_rst(rst), .i_avs_address(address),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
        .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .i_lookup_valid(lk_valid),
        .i_lookup_addr(lk_addr), .i_lookup_is_io(lk_io), .o_lookup_done(lk_done),
        .o_mem_hit(mem_hit), .o_pref_hit(pref_hit), .o_io_hit(io_hit));
    bfw_host_model i_bfw_host_model (.i_clock(clock), .i_waitrequest(waitreq),
        .o_address(address), .o_read(rd), .o_write(wr), .o_writedata(wdata),
        .o_byteenable(be));

    // xorshift source for data, lanes and gaps
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // reference decision {mem, pref, io} from the shadow words
    function automatic logic [2:0] ref_hit(input logic [63:0] a, input logic io);
        logic [63:0] pb, pt;
        logic [31:0] mb, mt, ib, it;
        logic lo;
        mb = {m[1][15:4], 20'h00000};
        mt = {m[1][31:20], 20'hfffff};
        pb = {m[3], m[2][15:4], 20'h00000};
        pt = {m[4], m[2][31:20], 20'hfffff};
        ib = {m[5][15:0], m[0][7:4], 12'h000};
        it = {m[5][31:16], m[0][15:12], 12'hfff};
        lo = (a[63:32] == 32'h00000000);
        return {!io && lo && a[31:0] >= mb && a[31:0] <= mt, !io && a >= pb && a <= pt,
            io && lo && a[31:0] >= ib && a[31:0] <= it};
    endfunction
    task automatic cmp32(input string what, input logic [31:0] e, input logic [31:0] s);
        num_checks++;
        if (s !== e) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic cmp3(input string what, input logic [2:0] e, input logic [2:0] s);
        num_checks++;
        if (s !== e) begin
            fail_count++;
            $display("unexpected %s expected %b seen %b", what, e, s);
        end
    endtask
    // write through the host, shadow keeps only the writable lanes
    task automatic wr_word(input int i, input logic [31:0] d, input logic [3:0] b);
        for (int k = 0; k < 4; k++) if (b[k]) m[i][8*k +: 8] = d[8*k +: 8];
        m[i] = (m[i] & WR_MASK[i]) | RO_BITS[i];
        i_bfw_host_model.xfer(1'b1, 8'h1c + 8'(4 * i), d, b, int'(xs() % 3));
    endtask
    task automatic rd_word(input logic [7:0] a, input logic [31:0] e);
        exp_rd.push_back(e);
        i_bfw_host_model.xfer(1'b0, a, xs(), 4'(xs()), int'(xs() % 2));
    endtask
    task automatic look(input logic [63:0] a, input logic io);
        @(posedge clock);
        lk_valid <= 1'b1;
        lk_addr <= a;
        lk_io <= io;
        exp_lk.push_back(ref_hit(a, io));
    endtask
    task automatic close_out();
        if (exp_rd.size() + exp_lk.size() != 0) fail_count++;
        if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // result watcher: oldest note against each finished read or lookup
    always @(posedge clock) begin
        if (rd === 1'b1 && waitreq === 1'b0)
            cmp32("readdata", exp_rd.size() ? exp_rd.pop_front() : 'x, rdata);
        if (lk_done === 1'b1)
            cmp3("hit flags", exp_lk.size() ? exp_lk.pop_front() : 'x,
                {mem_hit, pref_hit, io_hit});
    end
    // hang guard, far beyond the expected run
    initial begin
        repeat (20000) @(posedge clock);
        fail_count++;
        close_out();
    end
    initial begin
        rst = 1'b1;
        lk_valid = 1'b0;
        lk_addr = 64'h0000000000000000;
        lk_io = 1'b0;
        for (int i = 0; i < 7; i++) m[i] = RO_BITS[i];
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        // reset values, then an unmapped place
        for (int i = 0; i < 7; i++) begin
            rd_word(8'h1c + 8'(4 * i), m[i]);
        end
        rd_word(8'h38, 32'h00000000);
        // all ones then all zeros; fixed bits must hold
        for (int p = 0; p < 2; p++) for (int i = 0; i < 7; i++) begin
            wr_word(i, p ? 32'h00000000 : 32'hffffffff, 4'hf);
            rd_word(8'h1c + 8'(4 * i), m[i]);
        end
        // random data on random lanes, with unmapped writes between
        for (int n = 0; n < 40; n++) begin
            i_bfw_host_model.xfer(1'b1, 8'h38, xs(), 4'hf, 0);
            wr_word(int'(xs() % 7), xs(), 4'(xs()));
            rd_word(8'h1c + 8'(4 * (n % 7)), m[n % 7]);
        end
        // mid-run reset must clear every writable field again
        @(posedge clock);
        rst <= 1'b1;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            m[i] = RO_BITS[i];
            rd_word(8'h1c + 8'(4 * i), m[i]);
        end
        // fixed windows, every edge probed one below, on and one above
        for (int i = 0; i < 6; i++) wr_word(i, WIN_CFG[i], 4'hf);
        for (int k = 0; k < 6; k++) for (int d = -1; d < 2; d++) begin
            look(EDGES[k] + 64'(d), 1'b0);
            look(EDGES[k] + 64'(d), 1'b1);
        end
        for (int n = 0; n < 20; n++) look({32'(xs() % 3), xs()}, 1'(xs() % 2));
        @(posedge clock);
        lk_valid <= 1'b0;
        repeat (4) @(posedge clock);
        close_out();
    end
endmodule
`default_nettype wire
